// File: shift_alu_defs.svh
`ifndef SHIFT_ALU_DEFS_SVH
`define SHIFT_ALU_DEFS_SVH

// Register byte offsets.
`define OFF_CTRL        8'h00
`define OFF_SRC_A       8'h04
`define OFF_SRC_B       8'h08
`define OFF_RESULT      8'h0C
`define OFF_STATUS      8'h10
`define OFF_FAST_MEM    8'h14

// Control register fields.
`define CTRL_START      0
`define CTRL_FIELD_LO   1
`define CTRL_FIELD_HI   9

// Status register fields.
`define STAT_DONE       0
`define STAT_BRANCH     1
`define STAT_OVERFLOW   2
`define STAT_MEM_UPD    3

// Datapath figures.
`define DATA_W          16
`define SIGN_BIT        15
`define VAR_AMT_W       5
`define ARITH_AMT_W     4

// Reset values.
`define RST_WORD16      16'h0000
`define RST_WORD32      32'h0000_0000

// Branch condition encodings.
`define BC_NEVER        3'h0
`define BC_ALWAYS       3'h1
`define BC_ZERO         3'h2
`define BC_NONZERO      3'h3
`define BC_NEGATIVE     3'h4
`define BC_POSITIVE     3'h5

`endif

// File: shift_alu_pkg.sv
package shift_alu_pkg;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } state_t;

    typedef struct packed {
        logic       update_memory_field;
        logic [2:0] branch_cond;
        logic [3:0] modulo_select_field;
        logic       op_arith;
    } ctrl_t;

    typedef struct packed {
        logic mem_upd;
        logic overflow;
        logic branch;
        logic done;
    } status_t;

endpackage : shift_alu_pkg

// File: signed_shift_alu.sv
`timescale 1ns/100ps
`include "shift_alu_defs.svh"
// Notes on behaviour
// - Variable shift uses low five bits of B.
// - Right variable shift fills high bits zero.
// - Left variable shift fills low bits zero.
// - Negative amount shifts right by its magnitude.
// - Positive amount shifts left by its value.
// - Result wrapped by the modulo select field.
// - Result drives branch and fast memory update.
// - Arithmetic shift moves A right, keeping sign.
// - Arithmetic count from B low four bits.
module signed_shift_alu (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Execution events
    output logic             branch_taken,
    output logic             mem_update
);

    // Width of the datapath and of every operand register.
    localparam int DW = `DATA_W;

    // Bus state.
    logic                    wr_pend_q, wr_pend_d;
    logic [7:0]              wr_addr_q, wr_addr_d;
    logic [31:0]             hrdata_q, hrdata_d;
    logic                    ready_q, ready_d;
    logic                    resp_q, resp_d;
    // Software visible state.
    shift_alu_pkg::ctrl_t    ctrl_q, ctrl_d;
    shift_alu_pkg::status_t  stat_q, stat_d;
    shift_alu_pkg::state_t   state_q, state_d;
    logic [DW-1:0]           src_a_q, src_a_d;
    logic [DW-1:0]           src_b_q, src_b_d;
    logic [DW-1:0]           result_q, result_d;
    logic [DW-1:0]           fast_mem_q, fast_mem_d;
    logic                    branch_q, branch_d;
    logic                    mem_upd_q, mem_upd_d;
    // Combinational execution result.
    logic [DW-1:0]           exec_val;
    logic [DW-1:0]           var_val;
    logic [DW-1:0]           arith_val;
    logic                    addr_take;
    // Decoded execution events.
    logic                    start_req;
    logic                    exec_now;
    logic                    branch_hit;

    function automatic logic [DW-1:0] shift_variable(input logic [DW-1:0] a,
                                                     input logic [`VAR_AMT_W-1:0] amt);
        logic [`VAR_AMT_W-1:0] mag;
        // The magnitude is the two's complement of the amount; only -16 needs its top bit.
        mag = `VAR_AMT_W'(~amt + `VAR_AMT_W'(1));
        if (amt[`VAR_AMT_W-1]) begin
            // A magnitude of 16 empties the word entirely.
            shift_variable = a >> mag;
        end else begin
            // Only four bits count on this side, so the largest left shift is 15.
            shift_variable = a << amt[`VAR_AMT_W-2:0];
        end
    endfunction : shift_variable

    function automatic logic [DW-1:0] shift_arith(input logic [DW-1:0] a,
                                                  input logic [`ARITH_AMT_W-1:0] amt);
        // A four-bit count tops out at 15, so the sign bit always survives.
        shift_arith = DW'($signed(a) >>> amt);
    endfunction : shift_arith

    function automatic logic [DW-1:0] apply_modulo(input logic [DW-1:0] v,
                                                   input logic [3:0] sel);
        logic [DW-1:0] mask;
        mask = DW'((DW'(1) << sel) - DW'(1));
        // A zero selection keeps the full word width.
        apply_modulo = (sel == 4'h0) ? v : (v & mask);
    endfunction : apply_modulo

    // Condition codes without a meaning never branch.
    function automatic logic branch_eval(input logic [DW-1:0] v,
                                         input logic [2:0] cond);
        case (cond)
            `BC_NEVER:    branch_eval = 1'b0;
            `BC_ALWAYS:   branch_eval = 1'b1;
            `BC_ZERO:     branch_eval = (v == `RST_WORD16);
            `BC_NONZERO:  branch_eval = (v != `RST_WORD16);
            `BC_NEGATIVE: branch_eval = v[`SIGN_BIT];
            `BC_POSITIVE: branch_eval = ~v[`SIGN_BIT] && (v != `RST_WORD16);
            default:      branch_eval = 1'b0;
        endcase
    endfunction : branch_eval

    // Unmapped offsets read as zero, and the start bit always reads back as zero.
    function automatic logic [31:0] read_mux(input logic [7:0] off);
        case (off)
            `OFF_CTRL:     read_mux = {22'h0, ctrl_q, 1'b0};
            `OFF_SRC_A:    read_mux = {16'h0000, src_a_q};
            `OFF_SRC_B:    read_mux = {16'h0000, src_b_q};
            `OFF_RESULT:   read_mux = {16'h0000, result_q};
            `OFF_STATUS:   read_mux = {28'h0000000, stat_q};
            `OFF_FAST_MEM: read_mux = {16'h0000, fast_mem_q};
            default:       read_mux = `RST_WORD32;
        endcase
    endfunction : read_mux

    // Write one to clear; a zero leaves the flag as it is.
    function automatic logic clear_on_one(input logic flag, input logic wbit);
        clear_on_one = flag & ~wbit;
    endfunction : clear_on_one

    // A write lands in its data phase, one cycle after its address was taken.
    function automatic logic wr_hit(input logic [7:0] off);
        wr_hit = wr_pend_q && (wr_addr_q == off);
    endfunction : wr_hit

    // Registers hold the low half of the bus word; the upper bits are dropped on a write.
    function automatic logic [DW-1:0] low_half(input logic [31:0] w);
        low_half = w[DW-1:0];
    endfunction : low_half

    // An address phase is taken only while the bus is ready.
    assign addr_take = hsel && htrans[1] && hready;

    // Execution datapath. Both shifters run every cycle and the control word picks one,
    // which keeps the path from the operand flops to the result short and fixed.
    always_comb begin
        var_val   = shift_variable(src_a_q, src_b_q[`VAR_AMT_W-1:0]);
        arith_val = shift_arith(src_a_q, src_b_q[`ARITH_AMT_W-1:0]);
        if (ctrl_q.op_arith) begin
            exec_val = arith_val;
        end else begin
            exec_val = var_val;
        end
        exec_val = apply_modulo(exec_val, ctrl_q.modulo_select_field);
    end

    // Bus interface. The slave never stretches a transfer and always answers OKAY, so
    // hready and hresp are flops: hready leaves its reset value of zero once after reset, and hresp never does.
    // Only whole-word transfers are expected; hsize is not decoded.
    always_comb begin
        wr_pend_d = addr_take && hwrite;
        wr_addr_d = addr_take ? haddr[7:0] : wr_addr_q;
        // Read data is fetched at the address phase so hrdata comes from a flop.
        hrdata_d  = (addr_take && !hwrite) ? read_mux(haddr[7:0]) : hrdata_q;
        ready_d   = 1'b1;
        resp_d    = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q  <= `RST_WORD32;
            ready_q   <= 1'b0;
            resp_q    <= 1'b0;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            hrdata_q  <= hrdata_d;
            ready_q   <= ready_d;
            resp_q    <= resp_d;
        end
    end

    // Execution events shared by the register and sequencer groups.
    always_comb begin
        start_req  = wr_hit(`OFF_CTRL) && hwdata[`CTRL_START];
        exec_now   = (state_q == shift_alu_pkg::ST_EXEC);
        branch_hit = branch_eval(exec_val, ctrl_q.branch_cond);
    end

    // Software visible registers.
    always_comb begin
        ctrl_d     = ctrl_q;
        stat_d     = stat_q;
        src_a_d    = src_a_q;
        src_b_d    = src_b_q;
        result_d   = result_q;
        fast_mem_d = fast_mem_q;

        // Bus writes land first; an execution below may overwrite them.
        if (wr_hit(`OFF_CTRL)) begin
            ctrl_d = shift_alu_pkg::ctrl_t'(hwdata[`CTRL_FIELD_HI:`CTRL_FIELD_LO]);
        end

        if (wr_hit(`OFF_SRC_A)) begin
            src_a_d = low_half(hwdata);
        end

        if (wr_hit(`OFF_SRC_B)) begin
            src_b_d = low_half(hwdata);
        end

        if (wr_hit(`OFF_RESULT)) begin
            result_d = low_half(hwdata);
        end

        // Software may also preload the fast-memory word.
        if (wr_hit(`OFF_FAST_MEM)) begin
            fast_mem_d = low_half(hwdata);
        end

        if (wr_hit(`OFF_STATUS)) begin
            stat_d.done     = clear_on_one(stat_q.done, hwdata[`STAT_DONE]);
            stat_d.branch   = clear_on_one(stat_q.branch, hwdata[`STAT_BRANCH]);
            stat_d.mem_upd  = clear_on_one(stat_q.mem_upd, hwdata[`STAT_MEM_UPD]);
            // Overflow belongs to software alone; no shift touches it.
            stat_d.overflow = hwdata[`STAT_OVERFLOW];
        end

        // Setting a flag here wins over a clear in the same cycle.
        if (exec_now) begin
            result_d    = exec_val;
            stat_d.done = 1'b1;
            if (branch_hit) begin
                stat_d.branch = 1'b1;
            end
            if (ctrl_q.update_memory_field) begin
                fast_mem_d     = exec_val;
                stat_d.mem_upd = 1'b1;
            end
        end

        // A restart keeps done low until the new run has finished.
        if (start_req) begin
            stat_d.done = 1'b0;
        end
    end

    // Reset clears every software register; no state survives it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q     <= '0;
            stat_q     <= '0;
            src_a_q    <= `RST_WORD16;
            src_b_q    <= `RST_WORD16;
            result_q   <= `RST_WORD16;
            fast_mem_q <= `RST_WORD16;
        end else begin
            ctrl_q     <= ctrl_d;
            stat_q     <= stat_d;
            src_a_q    <= src_a_d;
            src_b_q    <= src_b_d;
            result_q   <= result_d;
            fast_mem_q <= fast_mem_d;
        end
    end

    // Sequencer: a start puts the block in EXEC for one cycle, in which the result, the
    // status flags and the event pulses are all registered together.
    always_comb begin
        state_d   = state_q;
        branch_d  = 1'b0;
        mem_upd_d = 1'b0;
        case (state_q)
            shift_alu_pkg::ST_IDLE: begin
                // Only a start leaves idle; nothing runs on its own.
                if (start_req) begin
                    state_d = shift_alu_pkg::ST_EXEC;
                end
            end
            shift_alu_pkg::ST_EXEC: begin
                // A start written now runs again with the new control word.
                state_d   = start_req ? shift_alu_pkg::ST_EXEC : shift_alu_pkg::ST_IDLE;
                branch_d  = branch_hit;
                mem_upd_d = ctrl_q.update_memory_field;
            end
            default: begin
                state_d = shift_alu_pkg::ST_IDLE;
            end
        endcase
    end

    // Each EXEC cycle gives one cycle of event pulse; a start written during EXEC runs two pulses together.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q   <= shift_alu_pkg::ST_IDLE;
            branch_q  <= 1'b0;
            mem_upd_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            branch_q  <= branch_d;
            mem_upd_q <= mem_upd_d;
        end
    end

    // Every output is a flop; nothing combinational reaches a pin.
    assign hrdata       = hrdata_q;
    assign hreadyout    = ready_q;
    assign hresp        = resp_q;
    assign branch_taken = branch_q;
    assign mem_update   = mem_upd_q;

endmodule : signed_shift_alu

// File: signed_shift_alu_asserts.sv
`timescale 1ns/100ps
module signed_shift_alu_asserts (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus and events
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        branch_taken,
    input wire logic        mem_update
);
    logic [9:0] ap_d;
    logic [9:0] ap_q;
    logic       ovf_d;
    logic       ovf_q;
    logic       start_w;
    logic       stat_rd;
    assign start_w = ap_q[9] && ap_q[8] && ap_q[7:0] == 8'h00 && hwdata[0] && hready;
    assign stat_rd = ap_q[9] && !ap_q[8] && ap_q[7:0] == 8'h10;
    always_comb begin
        ap_d  = {hsel && htrans[1] && hready, hwrite, haddr[7:0]};
        ovf_d = ovf_q;
        if (ap_q[9] && ap_q[8] && ap_q[7:0] == 8'h10 && hready) begin
            ovf_d = hwdata[2];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_q  <= 10'h000;
            ovf_q <= 1'b0;
        end else begin
            ap_q  <= ap_d;
            ovf_q <= ovf_d;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence seq_start_always;
        start_w && hwdata[8:6] == 3'h1;
    endsequence
    sequence seq_event;
        branch_taken || mem_update;
    endsequence
    AST_BR_ALWAYS: assert property (seq_start_always |-> ##2 branch_taken)
        else $error("branch not taken on always condition");
    AST_BR_NEVER: assert property (start_w && hwdata[8:6] == 3'h0 |-> ##2 !branch_taken)
        else $error("branch taken on never condition");
    AST_MEM_SET: assert property (start_w && hwdata[9] |-> ##2 mem_update)
        else $error("memory update missing");
    AST_MEM_CLR: assert property (start_w && !hwdata[9] |-> ##2 !mem_update)
        else $error("memory update without request");
    AST_BR_CAUSE: assert property (branch_taken |-> $past(start_w, 2))
        else $error("branch pulse without execution");
    AST_PULSE: assert property (seq_event |=> !branch_taken && !mem_update)
        else $error("event pulse longer than one cycle");
    AST_OVF_KEEP: assert property (stat_rd |-> hrdata[2] == ovf_q)
        else $error("overflow flag changed");
    AST_OKAY: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    AST_READY_HOLDS: assert property (hreadyout |=> hreadyout)
        else $error("ready dropped");
endmodule : signed_shift_alu_asserts

bind signed_shift_alu signed_shift_alu_asserts u_asserts (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .branch_taken(branch_taken), .mem_update(mem_update));

// File: test_signed_shift_alu.sv
`timescale 1ns/100ps
module test_signed_shift_alu;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        branch_taken;
    logic        mem_update;
    logic [31:0] rv;
    int          bad_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    signed_shift_alu u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .branch_taken(branch_taken),
        .mem_update(mem_update));
    initial begin
        forever #12.5 hclk = ~hclk;
    end
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    task check(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : check
    // The master holds each phase until it sees ready at a rising edge.
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask : xfer
    function automatic logic br_exp(input logic [2:0] c, input logic [15:0] r);
        case (c)
            3'h1: return 1'b1;
            3'h2: return r == 16'h0;
            3'h3: return r != 16'h0;
            3'h4: return r[15];
            3'h5: return !r[15] && r != 16'h0;
            default: return 1'b0;
        endcase
    endfunction : br_exp
    task run(input logic op, input logic [15:0] a, input logic [15:0] b, input logic [3:0] m,
             input logic [2:0] c, input logic u, input logic [15:0] e);
        xfer(1'b1, 32'h04, {16'h0, a});
        xfer(1'b1, 32'h08, {16'h0, b});
        xfer(1'b1, 32'h00, {22'h0, u, c, m, op, 1'b1});
        rv = 32'h0;
        for (int i = 0; i < 8 && rv[0] !== 1'b1; i++) xfer(1'b0, 32'h10, 32'h0);
        check("status", rv, {28'h0, u, 1'b1, br_exp(c, e), 1'b1});
        xfer(1'b0, 32'h0C, 32'h0);
        check("result", rv, {16'h0, e});
        // Writing ones clears the sticky flags while the overflow bit is rewritten as one.
        xfer(1'b1, 32'h10, 32'hF);
    endtask : run
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, 32'h0C, 32'h0);
        check("result reset", rv, 32'h0);
        xfer(1'b0, 32'h18, 32'h0);
        check("unmapped", rv, 32'h0);
        xfer(1'b1, 32'h10, 32'h4);
        run(1'h0, 16'h8421, 16'h0003, 4'h0, 3'h5, 1'h1, 16'h2108);
        run(1'h0, 16'hFFFF, 16'h000F, 4'h0, 3'h4, 1'h0, 16'h8000);
        run(1'h0, 16'h8001, 16'h001F, 4'h0, 3'h3, 1'h1, 16'h4000);
        run(1'h0, 16'hFFFF, 16'h0010, 4'h0, 3'h2, 1'h0, 16'h0000);
        run(1'h0, 16'hF000, 16'hFFFD, 4'h0, 3'h1, 1'h1, 16'h1E00);
        run(1'h1, 16'h8000, 16'h0004, 4'h0, 3'h4, 1'h0, 16'hF800);
        run(1'h1, 16'h8010, 16'h0013, 4'h0, 3'h0, 1'h1, 16'hF002);
        run(1'h1, 16'h7000, 16'h0002, 4'h0, 3'h6, 1'h0, 16'h1C00);
        run(1'h0, 16'h1234, 16'h0000, 4'h4, 3'h5, 1'h0, 16'h0004);
        run(1'h0, 16'h00F0, 16'h0001, 4'h8, 3'h3, 1'h1, 16'h00E0);
        xfer(1'b0, 32'h10, 32'h0);
        check("status final", rv, 32'h4);
        end_of_test();
    end
endmodule : test_signed_shift_alu
